// ==== common/our_defines.svh ====
// offsets-free constants for the outdoor unit reply framer: codes and counts
// assumes: included once per compilation unit by bare name
`ifndef OUR_DEFINES_SVH
`define OUR_DEFINES_SVH
`define OUR_FR_CMD_REPLY   8'hE2
`define OUR_FR_ACK         8'hE4
`define OUR_FR_NAK_UNSUP   8'hE5
`define OUR_FR_NAK_PARITY  8'hE6
`define OUR_FR_NAK_FORMAT  8'hE7
`define OUR_FR_PWD_A       8'hEB
`define OUR_FR_PWD_B       8'hEC
`define OUR_FR_SPECIAL     8'hED
`define OUR_FR_CRC         8'hEE
`define OUR_FR_MORE        8'hEF
`define OUR_FR_MASTER_ERR  8'hF2
`define OUR_SUB_EUI        8'hE1
`define OUR_SUB_PWD_BASE   8'hF0
`define OUR_SUB_PWD_FINAL  8'hFE
`define OUR_SUB_LOCKED     8'hFF
`define OUR_SUB_CRC        8'h00
`define OUR_BLK_MIN        8'h01
`define OUR_BLK_MAX        8'h2C
`define OUR_ADDR_ANY       8'h80
`define OUR_ADDR_INDOOR    8'h81
`define OUR_ADDR_OUTDOOR   8'h82
`define OUR_ADDR_FUTURE    8'h83
`define OUR_LOCK_COUNT     4'h6
`define OUR_MAX_REPLY      4'h8
`define OUR_HINT_BIT       1
`endif

// ==== common/our_pkg.sv ====
// types for the outdoor unit reply framer
// assumes: our_defines.svh provides the numeric constants
package our_pkg;
  typedef enum logic [2:0] {
    OUR_RQ_ACK,
    OUR_RQ_UNSUP,
    OUR_RQ_BLOCK,
    OUR_RQ_EUI,
    OUR_RQ_PWD,
    OUR_RQ_MORE
  } our_req_t;

  typedef struct packed {
    logic [7:0] data;
    logic       parity;
  } our_byte_t;

  typedef struct packed {
    logic [7:0] code;
    logic [7:0] extra;
    logic       two;
  } our_reply_t;
endpackage : our_pkg

// ==== design/our_framer.sv ====
// reply framing and address filter for the outdoor unit end of the link
// assumes: a byte receiver upstream delivers bytes with their parity bit and
// a message end strobe; the unit's own command logic judges crc, format,
// support, password and identifier, and a transmitter downstream sends the
// reply bytes msb first, each with odd parity, at reply_ready_i pace.
`include "our_defines.svh"

module our_framer
  import our_pkg::*;
(
  input  wire logic       clk_i,
  input  wire logic       rstn_i,
  input  wire our_byte_t  rx_byte_i,
  input  wire logic       rx_valid_i,
  input  wire logic       rx_end_i,
  input  wire logic       crc_bad_i,
  input  wire logic       format_bad_i,
  input  wire logic       unsup_i,
  input  wire our_req_t   req_kind_i,
  input  wire logic [7:0] req_arg_i,
  input  wire logic       pwd_wrong_i,
  input  wire logic       pwd_right_i,
  input  wire logic       lock_clear_i,
  input  wire logic [3:0] data_len_i,
  input  wire logic       reply_ready_i,
  output logic            reply_valid_o,
  output our_reply_t      reply_o,
  output logic            data_go_o,
  output logic            ext_go_o,
  output logic            alarm_o,
  output logic            locked_o,
  output logic            addr_hit_o
);

  typedef enum logic [1:0] {ST_ADDR, ST_BODY, ST_SKIP} our_rx_t;

  our_rx_t    state;
  our_rx_t    next_state;
  logic       parity_bad;
  logic       first;
  logic [3:0] bad_pwd_cnt;
  logic [3:0] next_bad_pwd_cnt;
  our_reply_t next_reply;
  logic       pend;

  // every check below runs on the one clock and rests during reset
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (!rstn_i);

  wire byte_odd_ok = ^{rx_byte_i.data, rx_byte_i.parity};
  wire addr_mine   = (rx_byte_i.data == `OUR_ADDR_OUTDOOR) ||
                     (rx_byte_i.data == `OUR_ADDR_ANY);
  wire frame_byte  = rx_valid_i && first;
  wire addr_byte   = rx_valid_i && state == ST_ADDR;
  wire msg_done    = rx_end_i && state == ST_BODY;
  wire bad_now     = parity_bad || (rx_valid_i && !byte_odd_ok);
  wire need_reply  = msg_done && !pend;
  wire pwd_ok_blk  = req_arg_i >= `OUR_BLK_MIN &&
                     req_arg_i <= `OUR_BLK_MAX;
  wire is_locked   = bad_pwd_cnt >= `OUR_LOCK_COUNT;
  wire long_reply  = data_len_i >= `OUR_MAX_REPLY;

  // receive states: framing byte, then address, then body (or skip for a foreign address) until end
  always_comb begin
    next_state = state;
    case (state)
      ST_ADDR: begin
        if (addr_byte && !first) begin
          next_state = addr_mine ? ST_BODY : ST_SKIP;
        end
      end
      ST_BODY: begin
        if (rx_end_i) begin
          next_state = ST_ADDR;
        end
      end
      ST_SKIP: begin
        if (rx_end_i) begin
          next_state = ST_ADDR;
        end
      end
      default: begin
        next_state = ST_ADDR;
      end
    endcase
  end

  // reply selection: parity before crc before format before support
  always_comb begin
    next_reply = '{code: `OUR_FR_ACK, extra: 8'h00, two: 1'b0};
    if (bad_now) begin
      next_reply.code = `OUR_FR_NAK_PARITY;
    end else if (crc_bad_i) begin
      next_reply = '{code: `OUR_FR_CRC, extra: `OUR_SUB_CRC,
                     two: 1'b1};
    end else if (format_bad_i) begin
      next_reply.code = `OUR_FR_NAK_FORMAT;
    end else if (unsup_i) begin
      next_reply.code = `OUR_FR_NAK_UNSUP;
    end else if (is_locked) begin
      next_reply = '{code: `OUR_FR_SPECIAL, extra: `OUR_SUB_LOCKED,
                     two: 1'b1};
    end else begin
      case (req_kind_i)
        OUR_RQ_BLOCK: begin
          if (pwd_ok_blk) begin
            next_reply = '{code: `OUR_FR_SPECIAL, extra: req_arg_i,
                           two: 1'b1};
          end else begin
            next_reply.code = `OUR_FR_NAK_FORMAT;
          end
        end
        OUR_RQ_EUI: begin
          next_reply = '{code: `OUR_FR_SPECIAL, extra: `OUR_SUB_EUI,
                         two: 1'b1};
        end
        OUR_RQ_PWD: begin
          // arg 0 means unnumbered, 'e' selects fe; else low nibble numbered
          next_reply = '{code: `OUR_FR_SPECIAL,
                         extra: (req_arg_i[3:0] == 4'hE) ?
                                `OUR_SUB_PWD_FINAL :
                                (`OUR_SUB_PWD_BASE | {4'h0, req_arg_i[3:0]}),
                         two: 1'b1};
        end
        OUR_RQ_MORE: begin
          next_reply.code = `OUR_FR_MORE;
        end
        default: begin
          next_reply.code = `OUR_FR_ACK;
        end
      endcase
    end
  end

  // consecutive wrong password count saturates at the lock level
  always_comb begin
    next_bad_pwd_cnt = bad_pwd_cnt;
    if (lock_clear_i || pwd_right_i) begin
      next_bad_pwd_cnt = 4'h0;
    end
    if (pwd_wrong_i && !is_locked) begin
      next_bad_pwd_cnt = bad_pwd_cnt + 4'h1;
    end
  end

  // a nak never carries data, so only the plain ack may start the data
  wire ack_next  = next_reply.code == `OUR_FR_ACK;
  wire has_data  = data_len_i != 4'h0;
  wire clean_msg = !bad_now && !crc_bad_i && !format_bad_i && !unsup_i &&
                   !is_locked;

  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      state       <= ST_ADDR;
      first       <= 1'b1;
      parity_bad  <= 1'b0;
      bad_pwd_cnt <= 4'h0;
    end else begin
      state       <= next_state;
      bad_pwd_cnt <= next_bad_pwd_cnt;
      if (rx_end_i) begin
        first      <= 1'b1;
        parity_bad <= 1'b0;
      end else if (rx_valid_i) begin
        first      <= 1'b0;
        parity_bad <= bad_now;
      end
    end
  end

  // a reply waits until the transmitter takes it; a message ending meanwhile gets none
  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      pend      <= 1'b0;
      reply_o   <= '0;
      data_go_o <= 1'b0;
      ext_go_o  <= 1'b0;
      alarm_o   <= 1'b0;
    end else begin
      if (need_reply) begin
        pend      <= 1'b1;
        reply_o   <= next_reply;
        // data only after a plain ack that asked for some bytes
        data_go_o <= ack_next && has_data;
        ext_go_o  <= ack_next && long_reply;
        alarm_o   <= alarm_o || next_reply.code == `OUR_FR_NAK_UNSUP;
      end else if (pend && reply_ready_i) begin
        pend      <= 1'b0;
        data_go_o <= 1'b0;
        ext_go_o  <= 1'b0;
      end
    end
  end

  assign reply_valid_o = pend;
  assign locked_o      = is_locked;
  assign addr_hit_o    = state == ST_BODY;

  // a foreign message ends in the skip state and raises no reply
  property p_skip;
    (rx_end_i && state == ST_SKIP) |=> !reply_valid_o || $past(pend);
  endproperty
  addr_filter_a: assert property (p_skip)
    else $error("reply to foreign address");

  addr_hit_a: assert property (
    (addr_byte && !first) |=> addr_hit_o == $past(addr_mine))
    else $error("address hit does not follow the address byte");

  // error replies, in the order in which they outrank each other
  parity_first_a: assert property (
    (need_reply && bad_now) |=>
      reply_o.code == `OUR_FR_NAK_PARITY)
    else $error("parity not reported first");

  parity_ok_a: assert property (
    (need_reply && !bad_now) |=>
      reply_o.code != `OUR_FR_NAK_PARITY)
    else $error("parity error reported for clean bytes");

  crc_reply_a: assert property (
    (need_reply && !bad_now && crc_bad_i) |=>
      reply_o.code == `OUR_FR_CRC && reply_o.extra == 8'h00 && reply_o.two)
    else $error("crc reply wrong");

  format_reply_a: assert property (
    (need_reply && !bad_now && !crc_bad_i && format_bad_i) |=>
      reply_o.code == `OUR_FR_NAK_FORMAT)
    else $error("format reply wrong");

  unsup_alarm_a: assert property (
    (reply_valid_o && reply_o.code == `OUR_FR_NAK_UNSUP) |-> alarm_o)
    else $error("unsupported without alarm");

  // the alarm stays up for the master to find until reset
  alarm_sticky_a: assert property (
    alarm_o |=> alarm_o)
    else $error("alarm dropped before reset");

  nak_nodata_a: assert property (
    (reply_valid_o && reply_o.code inside {8'hE5, 8'hE6, 8'hE7}) |->
      !data_go_o && !reply_o.two)
    else $error("data after nak");

  // special two-byte replies for locking, blocks, identifier, password
  lock_code_a: assert property (
    (bad_pwd_cnt >= 4'h6 && !bad_now && !crc_bad_i && !format_bad_i &&
     !unsup_i && need_reply) |=> reply_o.extra == 8'hFF)
    else $error("lock code missing");

  lock_hold_a: assert property (
    (locked_o && !lock_clear_i && !pwd_right_i) |=> locked_o)
    else $error("lock released without a clear");

  lock_free_a: assert property (
    (!locked_o && !pwd_wrong_i) |=> !locked_o)
    else $error("locked without a wrong password");

  block_reply_a: assert property (
    (need_reply && clean_msg && req_kind_i == OUR_RQ_BLOCK &&
     req_arg_i inside {[8'h01:8'h2C]}) |=>
      reply_o.code == 8'hED && reply_o.extra == $past(req_arg_i) &&
      reply_o.two)
    else $error("repeat block reply wrong");

  eui_reply_a: assert property (
    (need_reply && clean_msg && req_kind_i == OUR_RQ_EUI) |=>
      reply_o.code == 8'hED && reply_o.extra == 8'hE1 && reply_o.two)
    else $error("identifier reply wrong");

  pwd_reply_a: assert property (
    (need_reply && clean_msg && req_kind_i == OUR_RQ_PWD) |=>
      reply_o.code == 8'hED && reply_o.two &&
      reply_o.extra == {4'hF, $past(req_arg_i[3:0])})
    else $error("password reply wrong");

  // plain replies and what follows them
  ok_ack_a: assert property (
    (need_reply && clean_msg && req_kind_i == OUR_RQ_ACK) |=>
      reply_o.code == 8'hE4)
    else $error("clean message not acked");

  more_reply_a: assert property (
    (need_reply && clean_msg && req_kind_i == OUR_RQ_MORE) |=>
      reply_o.code == 8'hEF && !reply_o.two)
    else $error("continuation reply wrong");

  data_after_ack_a: assert property (
    (need_reply && clean_msg && req_kind_i == OUR_RQ_ACK &&
     data_len_i != 4'h0) |=> data_go_o)
    else $error("requested data not started after ack");

  ext_long_a: assert property (
    (need_reply && clean_msg && req_kind_i == OUR_RQ_ACK &&
     data_len_i >= 4'h8) |=> ext_go_o)
    else $error("long reply not sent as blocks");

  // a reply stands unchanged until the transmitter takes it
  one_reply_a: assert property (
    (reply_valid_o && !reply_ready_i) |=> reply_valid_o && $stable(reply_o))
    else $error("reply changed while pending");

  reply_taken_a: assert property (
    (reply_valid_o && reply_ready_i) |=> !reply_valid_o)
    else $error("reply still pending after it was taken");

  pend_drop_a: assert property (
    (msg_done && pend && !reply_ready_i) |=> $stable(reply_o))
    else $error("message during a pending reply replaced it");

  ack_c:    cover property (reply_valid_o && reply_o.code == `OUR_FR_ACK);
  parity_c: cover property (reply_valid_o &&
                            reply_o.code == `OUR_FR_NAK_PARITY);
  lock_c:   cover property (locked_o && reply_valid_o);
  skip_c:   cover property (state == ST_SKIP && rx_end_i);
  // the framing hint bit steers nothing: no party may rely on it
  hint_c:   cover property (frame_byte &&
                            rx_byte_i.data[`OUR_HINT_BIT]);

endmodule : our_framer

// ==== test/our_idu_model.sv ====
// indoor unit stand-in: sends master messages one byte at a time
// assumes: the bench clock; everything changes on the falling edge
module our_idu_model
  import our_pkg::*;
(
  input  wire logic clk_i,
  output our_byte_t rx_byte_o,
  output logic      rx_valid_o,
  output logic      rx_end_o
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    rx_byte_o  = our_byte_t'(9'h05A);
    rx_valid_o = 1'b0;
    rx_end_o   = 1'b0;
  end
  // odd parity on every byte; bad flips it on purpose
  task automatic send(input logic [7:0] b, input logic bad);
    @(negedge clk_i);
    rx_byte_o  = '{b, ~^b ^ bad};
    rx_valid_o = 1'b1;
    @(negedge clk_i);
    rx_valid_o = 1'b0;
    // a released bus must not look like the last byte
    rx_byte_o  = our_byte_t'(~rx_byte_o);
  endtask : send
  // ordinary command needing a reply opens with e2 this master
  // keeps f2 for error reports and sends none in these scenarios
  task automatic msg_body(input logic [7:0] adr, input logic bad);
    send(8'hE2, 1'b0);
    send(adr, 1'b0);
    send(8'h12, bad);
  endtask : msg_body
  // end strobe one idle cycle after the last byte, never with a byte
  task automatic msg_end();
    @(negedge clk_i);
    rx_end_o = 1'b1;
    @(negedge clk_i);
    rx_end_o = 1'b0;
  endtask : msg_end
endmodule : our_idu_model

// ==== test/our_framer_tb.sv ====
// bench for the reply framer: the idu model sends, the bench judges
// assumes: our_idu_model on the byte side; 50 MHz clock
module our_framer_tb
  import our_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic       clk_i, rstn_i, crc, fmt, uns, pwr, pok, lclr, rdy, pb;
  logic       rxv, rxe, rv, dgo, ego, alm, lck, hit;
  logic [7:0] arg, adr;
  logic [3:0] len;
  our_req_t   kind;
  our_byte_t  rxb;
  our_reply_t rep;
  int         errors, n_checks;
  our_idu_model idu (.clk_i(clk_i), .rx_byte_o(rxb), .rx_valid_o(rxv),
                     .rx_end_o(rxe));
  our_framer dut (.clk_i(clk_i), .rstn_i(rstn_i), .rx_byte_i(rxb),
    .rx_valid_i(rxv), .rx_end_i(rxe), .crc_bad_i(crc), .format_bad_i(fmt),
    .unsup_i(uns), .req_kind_i(kind), .req_arg_i(arg), .pwd_wrong_i(pwr),
    .pwd_right_i(pok), .lock_clear_i(lclr), .data_len_i(len),
    .reply_ready_i(rdy), .reply_valid_o(rv), .reply_o(rep),
    .data_go_o(dgo), .ext_go_o(ego), .alarm_o(alm), .locked_o(lck),
    .addr_hit_o(hit));
  initial begin
    clk_i = 1'b0;
    forever #10 clk_i = ~clk_i;
  end
  task automatic check(input logic [16:0] seen, input logic [16:0] exp);
    n_checks++;
    if (seen !== exp) begin
      errors++;
      $display("[FAIL] %0t seen %h exp %h", $time, seen, exp);
    end
  endtask : check
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : give_verdict
  // code 00 means no reply is due; one-byte replies compare extra as 00
  task automatic one(input logic [2:0] cfu, input our_req_t k,
                     input logic [7:0] a, input logic [3:0] l,
                     input logic [7:0] c, e, input logic t);
    int          i;
    logic        ack;
    logic [16:0] got;
    ack = (c == 8'hE4);
    @(negedge clk_i);
    {crc, fmt, uns} = cfu;
    kind = k;
    arg  = a;
    len  = l;
    idu.msg_body(adr, pb);
    check(17'(hit), 17'(adr == 8'h82 || adr == 8'h80));
    idu.msg_end();
    for (i = 0; i < 20 && rv !== 1'b1; i++) @(negedge clk_i);
    check(17'(rv), 17'(c != 8'h00));
    if (rv === 1'b1) begin
      got = {rep.code, rep.two ? rep.extra : 8'h00, rep.two};
      check(got, {c, e, t});
      check(17'({dgo, ego}), 17'({ack && l != 0, ack && l >= 8}));
      @(negedge clk_i);
      rdy = 1'b1;
      @(negedge clk_i);
      rdy = 1'b0;
      @(negedge clk_i);
      check(17'(rv), 17'h0_0000);
    end
  endtask : one
  task automatic wrong(input int n);
    repeat (n) begin
      @(negedge clk_i);
      pwr = 1'b1;
      @(negedge clk_i);
      pwr = 1'b0;
    end
  endtask : wrong
  task automatic t_ack();
    one(3'b000, OUR_RQ_ACK, 8'h00, 4'h3, 8'hE4, 8'h00, 1'b0);
    one(3'b000, OUR_RQ_ACK, 8'h00, 4'h7, 8'hE4, 8'h00, 1'b0);
    one(3'b000, OUR_RQ_ACK, 8'h00, 4'h8, 8'hE4, 8'h00, 1'b0);
    check(17'(alm), 17'h0_0000);
    $display("t_ack done");
  endtask : t_ack
  task automatic t_nak();
    pb = 1'b1;
    one(3'b111, OUR_RQ_ACK, 8'h00, 4'h3, 8'hE6, 8'h00, 1'b0);
    pb = 1'b0;
    one(3'b111, OUR_RQ_ACK, 8'h00, 4'h3, 8'hEE, 8'h00, 1'b1);
    one(3'b011, OUR_RQ_ACK, 8'h00, 4'h3, 8'hE7, 8'h00, 1'b0);
    one(3'b001, OUR_RQ_ACK, 8'h00, 4'h3, 8'hE5, 8'h00, 1'b0);
    check(17'(alm), 17'h0_0001);
    one(3'b000, OUR_RQ_ACK, 8'h00, 4'h0, 8'hE4, 8'h00, 1'b0);
    check(17'(alm), 17'h0_0001);
    $display("t_nak done");
  endtask : t_nak
  task automatic t_addr();
    adr = 8'h81;
    one(3'b000, OUR_RQ_ACK, 8'h00, 4'h0, 8'h00, 8'h00, 1'b0);
    adr = 8'h83;
    one(3'b000, OUR_RQ_ACK, 8'h00, 4'h0, 8'h00, 8'h00, 1'b0);
    adr = 8'h80;
    one(3'b000, OUR_RQ_ACK, 8'h00, 4'h1, 8'hE4, 8'h00, 1'b0);
    adr = 8'h82;
    $display("t_addr done");
  endtask : t_addr
  task automatic t_kind();
    one(3'b000, OUR_RQ_BLOCK, 8'h01, 4'h0, 8'hED, 8'h01, 1'b1);
    one(3'b000, OUR_RQ_BLOCK, 8'h2C, 4'h0, 8'hED, 8'h2C, 1'b1);
    one(3'b000, OUR_RQ_BLOCK, 8'h2D, 4'h0, 8'hE7, 8'h00, 1'b0);
    one(3'b000, OUR_RQ_BLOCK, 8'h00, 4'h0, 8'hE7, 8'h00, 1'b0);
    one(3'b000, OUR_RQ_EUI, 8'h00, 4'h0, 8'hED, 8'hE1, 1'b1);
    one(3'b000, OUR_RQ_MORE, 8'h00, 4'h0, 8'hEF, 8'h00, 1'b0);
    $display("t_kind done");
  endtask : t_kind
  task automatic t_pwd();
    one(3'b000, OUR_RQ_PWD, 8'h00, 4'h0, 8'hED, 8'hF0, 1'b1);
    one(3'b000, OUR_RQ_PWD, 8'h03, 4'h0, 8'hED, 8'hF3, 1'b1);
    one(3'b000, OUR_RQ_PWD, 8'h0E, 4'h0, 8'hED, 8'hFE, 1'b1);
    wrong(5);
    check(17'(lck), 17'h0_0000);
    wrong(1);
    check(17'(lck), 17'h0_0001);
    one(3'b000, OUR_RQ_ACK, 8'h00, 4'h2, 8'hED, 8'hFF, 1'b1);
    @(negedge clk_i);
    lclr = 1'b1;
    @(negedge clk_i);
    lclr = 1'b0;
    check(17'(lck), 17'h0_0000);
    wrong(6);
    @(negedge clk_i);
    pok = 1'b1;
    @(negedge clk_i);
    pok = 1'b0;
    check(17'(lck), 17'h0_0000);
    one(3'b000, OUR_RQ_ACK, 8'h00, 4'h2, 8'hE4, 8'h00, 1'b0);
    $display("t_pwd done");
  endtask : t_pwd
  initial begin
    {rstn_i, crc, fmt, uns, pwr, pok, lclr, rdy, pb} = '0;
    kind = OUR_RQ_ACK;
    arg  = 8'h00;
    len  = 4'h0;
    adr  = 8'h82;
    repeat (16) @(negedge clk_i);
    rstn_i = 1'b1;
    t_ack();
    t_nak();
    t_addr();
    t_kind();
    t_pwd();
    give_verdict();
  end
  // about 350 cycles are needed; the watchdog allows 5000
  initial begin
    #100us;
    errors++;
    give_verdict();
  end
endmodule : our_framer_tb
